// [pct_pkg.sv]
// constants, offsets and types of the power condition timer descriptor
// assumes a 10 MHz controller clock; imported by every design file
package pct_pkg;

  // clock and timer unit
  localparam int unsigned PCT_CLK_NS      = 100;
  localparam int unsigned PCT_TICK_MS     = 100;
  localparam int unsigned PCT_TICK_CYCLES =
    PCT_TICK_MS * 1000000 / PCT_CLK_NS;

  // special timer codes
  localparam logic [31:0] PCT_TIMER_INF = 32'hFFFF_FFFF;
  localparam logic [31:0] PCT_TIMER_OFF = 32'h0000_0000;

  // byte offsets inside the 64-byte descriptor
  localparam logic [5:0] PCT_OFF_FLAGS   = 6'h01;
  localparam logic [5:0] PCT_OFF_DEFAULT = 6'h04;
  localparam logic [5:0] PCT_OFF_SAVED   = 6'h08;
  localparam logic [5:0] PCT_OFF_ACTIVE  = 6'h0C;
  localparam logic [5:0] PCT_OFF_WAKE    = 6'h10;
  localparam logic [5:0] PCT_OFF_LOWER   = 6'h14;
  localparam logic [5:0] PCT_OFF_UPPER   = 6'h18;

  // bit positions in the condition flag byte
  localparam int unsigned PCT_FLG_SUPPORTED = 7;
  localparam int unsigned PCT_FLG_SAVABLE   = 6;
  localparam int unsigned PCT_FLG_CHANGE    = 5;
  localparam int unsigned PCT_FLG_DEF_EN    = 4;
  localparam int unsigned PCT_FLG_SAVED_EN  = 3;
  localparam int unsigned PCT_FLG_CUR_EN    = 2;

  // values fixed at manufacture (plain defaults)
  localparam logic [31:0] PCT_DEF_TIMER = 32'h0000_0064;
  localparam logic [31:0] PCT_DEF_WAKE  = 32'h0000_0000;
  localparam logic [31:0] PCT_DEF_LOWER = 32'h0000_0000;
  localparam logic [31:0] PCT_DEF_UPPER = 32'h0000_0000;

  // values after reset
  localparam logic [7:0] PCT_RST_BYTE = 8'h00;
  localparam logic [1:0] PCT_RST_LANE = 2'h0;

  typedef enum logic [1:0] {
    PCT_IDLE  = 2'b00,
    PCT_COUNT = 2'b01,
    PCT_DONE  = 2'b11
  } pct_cd_state_t;

endpackage

// [pct_countdown.sv]
// power condition countdown in 100 ms units
// assumes load_i and run_i come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pct_countdown
  import pct_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PCT_TICK_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        load_i,
  input  wire logic [31:0] value_i,
  input  wire logic        run_i,
  output logic             expire_o
);

  pct_cd_state_t state_q;
  logic [31:0]   pre_q;
  logic [31:0]   cnt_q;
  logic          tick_w;

  assign tick_w = (pre_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= PCT_IDLE;
      pre_q    <= 32'h0000_0000;
      cnt_q    <= 32'h0000_0000;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (!run_i) begin
        state_q <= PCT_IDLE;
      end else if (load_i) begin
        // restart at every completion
        state_q <= (value_i != PCT_TIMER_OFF) ? PCT_COUNT : PCT_IDLE; // R14
        pre_q   <= 32'h0000_0000;
        cnt_q   <= value_i;
      end else begin
        unique case (state_q)
          PCT_IDLE: begin
            state_q <= PCT_IDLE;
          end
          PCT_COUNT: begin
            pre_q <= tick_w ? 32'h0000_0000 : pre_q + 32'h0000_0001;
            // all ones never runs out
            if (tick_w && cnt_q != PCT_TIMER_INF) begin // R05
              cnt_q <= cnt_q - 32'h0000_0001;
              if (cnt_q == 32'h0000_0001) begin
                state_q  <= PCT_DONE; // R07
                expire_o <= 1'b1;     // R14
              end
            end
          end
          PCT_DONE: begin
            state_q <= PCT_DONE;
          end
          default: begin
            state_q <= PCT_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [pct_descriptor.sv]
// one power condition descriptor with its entry timer
// assumes command and read strobes come from same-clock controller logic
//
// Overview of operation
// [R01] current-enabled flag reads zero while feature off
// [R02] timer runs only when enabled, nonzero, flagged
// [R03] default/saved enable flags valid only if supported
// [R04] timer fields are 32-bit counts of 100 ms
// [R05] all ones means at or beyond maximum time
// [R06] saved timer loaded only by set command; reset also reloads it here with the default timer
// [R07] wait current timer after completion before entry
// [R08] current timer reads zero in three cases
// [R09] default timer fixed at manufacture
// [R10] recovery time reported, kept over resets
// [R11] report accepted timer bounds, zero unspecified
// [R12] supported flag shows condition support
// [R13] reserved bits and bytes read zero
// [R14] countdown restarts on completion, requests entry
`timescale 1ns/1ps
`default_nettype none
module pct_descriptor
  import pct_pkg::*;
#(
  parameter int unsigned TICK_CYCLES      = PCT_TICK_CYCLES,
  parameter logic        COND_SUPPORTED   = 1'b1,
  parameter logic        TIMER_SAVABLE    = 1'b1,
  parameter logic        TIMER_CHANGEABLE = 1'b1,
  parameter logic        DEFAULT_ENABLED  = 1'b1,
  parameter logic [31:0] DEFAULT_TIMER    = PCT_DEF_TIMER,
  parameter logic [31:0] WAKE_TIME        = PCT_DEF_WAKE,
  parameter logic [31:0] LOWER_BOUND      = PCT_DEF_LOWER,
  parameter logic [31:0] UPPER_BOUND      = PCT_DEF_UPPER
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        epc_enable_i,
  input  wire logic        cmd_done_i,
  input  wire logic        rd_i,
  input  wire logic [5:0]  rd_addr_i,
  input  wire logic        set_i,
  input  wire logic [31:0] set_value_i,
  input  wire logic        set_timer_en_i,
  input  wire logic        set_save_i,
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o,
  output logic             set_done_o,
  output logic             set_err_o,
  output logic             enter_req_o
);

  logic [31:0] saved_q;
  logic        saved_en_q;
  logic [31:0] act_q;
  logic        act_en_q;
  logic        shown_w;
  logic [31:0] act_shown_w;
  logic        run_w;
  logic        in_bounds_w;
  logic        set_ok_w;
  logic [7:0]  flags_w;
  logic [31:0] dword_w;

  function automatic logic [7:0] lane_of(input logic [31:0] dw,
                                         input logic [1:0]  lane);
    lane_of = dw[8*lane +: 8];
  endfunction

  // current enabled flag and current timer only shown while feature on, condition supported and timer enabled
  assign shown_w = epc_enable_i & COND_SUPPORTED & act_en_q;
  assign act_shown_w = shown_w ? act_q : PCT_TIMER_OFF; // R08
  assign run_w = shown_w & (act_q != PCT_TIMER_OFF); // R02

  // zero bound means unspecified; zero value disables
  assign in_bounds_w = (set_value_i == PCT_TIMER_OFF) |
    (((LOWER_BOUND == PCT_TIMER_OFF) | (set_value_i >= LOWER_BOUND)) &
     ((UPPER_BOUND == PCT_TIMER_OFF) | (set_value_i <= UPPER_BOUND))); // R11

  assign set_ok_w = epc_enable_i & COND_SUPPORTED & TIMER_CHANGEABLE &
                    in_bounds_w & (!set_save_i | TIMER_SAVABLE);

  always_comb begin
    flags_w = PCT_RST_BYTE; // R13
    flags_w[PCT_FLG_SUPPORTED] = COND_SUPPORTED; // R12
    flags_w[PCT_FLG_SAVABLE]   = COND_SUPPORTED & TIMER_SAVABLE;
    flags_w[PCT_FLG_CHANGE]    = COND_SUPPORTED & TIMER_CHANGEABLE;
    flags_w[PCT_FLG_DEF_EN]    = COND_SUPPORTED & DEFAULT_ENABLED; // R03
    flags_w[PCT_FLG_SAVED_EN]  = COND_SUPPORTED & saved_en_q; // R03
    flags_w[PCT_FLG_CUR_EN]    = shown_w; // R01
  end

  // 32-bit fields in 100 ms units, little endian in the log
  always_comb begin
    dword_w = PCT_TIMER_OFF; // R13
    unique case ({rd_addr_i[5:2], 2'b00})
      {PCT_OFF_FLAGS[5:2], 2'b00}: begin
        dword_w = {16'h0000, flags_w, 8'h00}; // R13
      end
      PCT_OFF_DEFAULT: begin
        dword_w = COND_SUPPORTED ? DEFAULT_TIMER : PCT_TIMER_OFF; // R09
      end
      PCT_OFF_SAVED: begin
        dword_w = COND_SUPPORTED ? saved_q : PCT_TIMER_OFF; // R04
      end
      PCT_OFF_ACTIVE: begin
        dword_w = act_shown_w; // R08
      end
      PCT_OFF_WAKE: begin
        dword_w = WAKE_TIME; // R10
      end
      PCT_OFF_LOWER: begin
        dword_w = LOWER_BOUND; // R11
      end
      PCT_OFF_UPPER: begin
        dword_w = UPPER_BOUND; // R11
      end
      default: begin
        dword_w = PCT_TIMER_OFF; // R13
      end
    endcase
  end

  // read port: one byte a cycle after the strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o  <= PCT_RST_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_i;
      if (rd_i) begin
        rd_data_o <= lane_of(dword_w, rd_addr_i[1:0]);
      end
    end
  end

  // timer settings; saved value reloaded with the default timer at reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_q      <= DEFAULT_TIMER;
      act_en_q   <= DEFAULT_ENABLED;
      saved_q    <= DEFAULT_TIMER;
      saved_en_q <= DEFAULT_ENABLED;
    end else if (set_i && set_ok_w) begin
      act_q    <= set_value_i;
      act_en_q <= set_timer_en_i;
      if (set_save_i) begin
        saved_q    <= set_value_i; // R06
        saved_en_q <= set_timer_en_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      set_done_o <= 1'b0;
      set_err_o  <= 1'b0;
    end else begin
      set_done_o <= set_i;
      set_err_o  <= set_i & !set_ok_w; // R11
    end
  end

  // a new timer value takes hold at the next completion; disabling stops the count at once
  pct_countdown #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_countdown (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .load_i    (cmd_done_i), // R14
    .value_i   (act_q),
    .run_i     (run_w), // R02
    .expire_o  (enter_req_o) // R07
  );

  // helper logic for the checks below
  logic [63:0] since_q;
  logic [31:0] loaded_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_q  <= 64'h0000_0000_0000_0000;
      loaded_q <= 32'h0000_0000;
    end else if (cmd_done_i) begin
      since_q  <= 64'h0000_0000_0000_0000;
      loaded_q <= act_q;
    end else begin
      since_q <= since_q + 64'h0000_0000_0000_0001;
    end
  end

  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  cur_en_off_a: assert property ( // R01
    rd_i && rd_addr_i == PCT_OFF_FLAGS && !epc_enable_i
    |=> !rd_data_o[PCT_FLG_CUR_EN])
    else $error("current enabled flag set while feature off");

  entry_gate_a: assert property ( // R02
    enter_req_o |-> $past(run_w))
    else $error("entry requested while timer not running");

  // default and saved enable flags may only show beside the supported flag
  flag_valid_a: assert property ( // R03
    rd_i && rd_addr_i == PCT_OFF_FLAGS
    |=> rd_data_o[PCT_FLG_SUPPORTED] ||
        (!rd_data_o[PCT_FLG_DEF_EN] && !rd_data_o[PCT_FLG_SAVED_EN]))
    else $error("enable flags shown for unsupported condition");

  infinite_hold_a: assert property ( // R05
    cmd_done_i && run_w && act_q == PCT_TIMER_INF
    |=> !enter_req_o [*8])
    else $error("infinite timer expired");

  saved_src_a: assert property ( // R06
    $changed(saved_q) |-> $past(set_i && set_save_i && set_ok_w))
    else $error("saved timer changed without set command");

  entry_wait_a: assert property ( // R07
    enter_req_o |->
      since_q >= 64'(loaded_q) * 64'(TICK_CYCLES))
    else $error("entry before current timer elapsed");

  act_zero_a: assert property ( // R08
    rd_i && rd_addr_i[5:2] == PCT_OFF_ACTIVE[5:2] && !shown_w
    |=> rd_data_o == 8'h00)
    else $error("current timer not zero while hidden");

  default_val_a: assert property ( // R09
    rd_i && rd_addr_i == PCT_OFF_DEFAULT && COND_SUPPORTED
    |=> rd_data_o == DEFAULT_TIMER[7:0])
    else $error("default timer byte wrong");

  wake_val_a: assert property ( // R10
    rd_i && rd_addr_i == PCT_OFF_WAKE
    |=> rd_data_o == WAKE_TIME[7:0] && rd_valid_o)
    else $error("recovery time byte wrong");

  bound_err_a: assert property ( // R11
    set_i && !in_bounds_w |=> set_err_o && set_done_o)
    else $error("out of bound timer accepted");

  supp_flag_a: assert property ( // R12
    rd_i && rd_addr_i == PCT_OFF_FLAGS
    |=> rd_data_o[PCT_FLG_SUPPORTED] == COND_SUPPORTED)
    else $error("supported flag wrong");

  rsvd_zero_a: assert property ( // R13
    rd_i && (rd_addr_i == 6'h00 || rd_addr_i >= 6'h1C)
    |=> rd_data_o == 8'h00)
    else $error("reserved byte not zero");

  set_ok_c: cover property (set_i && set_ok_w && set_save_i);
  set_bad_c: cover property (set_i && !set_ok_w);
  entry_c: cover property (enter_req_o);
  read_c: cover property (rd_i && rd_addr_i == PCT_OFF_ACTIVE);

endmodule
`default_nettype wire

// [pct_host_model.sv]
// host side model: set timer subcommands and command completions
// assumes the device samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pct_host_model (
  input  wire logic        clock_i,
  output logic             cmd_done_o,
  output logic             set_o,
  output logic [31:0]      value_o,
  output logic             timer_en_o,
  output logic             save_o
);
  initial begin
    cmd_done_o = 1'b0;
    set_o      = 1'b0;
    value_o    = 32'h0000_0000;
    timer_en_o = 1'b0;
    save_o     = 1'b0;
  end

  // only path besides reset that changes the saved timer; values driven as given, bounds left to the device
  task automatic issue_set(input logic [31:0] v, input logic en,
                           input logic sv);
    @(negedge clock_i);
    set_o      <= 1'b1;
    value_o    <= v;
    timer_en_o <= en;
    save_o     <= sv;
    @(negedge clock_i);
    set_o      <= 1'b0;
    // qualifiers go stale once taken, so show the inverse
    value_o    <= ~v;
    timer_en_o <= ~en;
    save_o     <= ~sv;
  endtask

  task automatic complete_cmd();
    @(negedge clock_i);
    cmd_done_o <= 1'b1;
    @(negedge clock_i);
    cmd_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [pct_descriptor_tb.sv]
// self-checking bench for the power condition descriptor
// assumes pct_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module pct_descriptor_tb;
  import pct_pkg::*;
  localparam int unsigned TK = 2;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        epc_enable_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [5:0]  rd_addr_i = 6'h00;
  logic        cmd_done, set, en, sv;
  logic [31:0] value;
  logic [7:0]  rd_data_o;
  logic        rd_valid_o, set_done_o, set_err_o, enter_req_o;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          k;
  logic [5:0]  offs [8] = '{6'h00, 6'h04, 6'h08, 6'h0C,
                            6'h10, 6'h14, 6'h18, 6'h1C};
  logic [31:0] exps [8] = '{32'h0000_F800, 32'h0000_0064, 32'h0000_0064,
                            32'h0000_0000, 32'h0000_0000, 32'h0000_0002,
                            32'h0000_0014, 32'h0000_0000};

  always #50 clock_i = ~clock_i;

  pct_host_model u_host (.clock_i(clock_i), .cmd_done_o(cmd_done),
    .set_o(set), .value_o(value), .timer_en_o(en), .save_o(sv));

  // short tick keeps countdowns to a few cycles
  pct_descriptor #(.TICK_CYCLES(TK), .LOWER_BOUND(32'h0000_0002),
    .UPPER_BOUND(32'h0000_0014)) u_dut (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .epc_enable_i(epc_enable_i),
    .cmd_done_i(cmd_done), .rd_i(rd_i), .rd_addr_i(rd_addr_i),
    .set_i(set), .set_value_i(value), .set_timer_en_i(en),
    .set_save_i(sv), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .set_done_o(set_done_o), .set_err_o(set_err_o),
    .enter_req_o(enter_req_o));

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // dword read, little endian, one byte per request
  task automatic rd32(input logic [5:0] a, output logic [31:0] q);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_i);
      rd_i      <= 1'b1;
      rd_addr_i <= a + 6'(i);
      @(negedge clock_i);
      rd_i      <= 1'b0;
      chk("rd_valid", {31'h0, rd_valid_o}, 32'h1);
      q[8*i+:8] = rd_data_o;
    end
  endtask

  task automatic do_set(input logic [31:0] v, input logic e,
                        input logic s, input logic err);
    u_host.issue_set(v, e, s);
    chk("set_done", {31'h0, set_done_o}, 32'h1);
    chk("set_err", {31'h0, set_err_o}, {31'h0, err});
  endtask

  // cycles from the completion until the entry request, capped
  task automatic time_entry(input int cap);
    u_host.complete_cmd();
    k = 1;
    while (enter_req_o !== 1'b1 && k < cap) begin
      @(negedge clock_i);
      k++;
    end
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (3) @(negedge clock_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd32(offs[i], d);
      chk("map", d, exps[i]);
    end
    do_set(32'h0000_0003, 1'b1, 1'b1, 1'b1);
    $display("test map_feature_off done");
    epc_enable_i <= 1'b1;
    rd32(6'h00, d);
    chk("flags_on", d, 32'h0000_FC00);
    rd32(PCT_OFF_ACTIVE, d);
    chk("current_on", d, 32'h0000_0064);
    do_set(32'h0000_0001, 1'b1, 1'b1, 1'b1);
    do_set(32'h0000_0015, 1'b1, 1'b1, 1'b1);
    do_set(32'h0000_0003, 1'b1, 1'b1, 1'b0);
    rd32(PCT_OFF_SAVED, d);
    chk("saved", d, 32'h0000_0003);
    rd32(PCT_OFF_ACTIVE, d);
    chk("current", d, 32'h0000_0003);
    time_entry(40);
    chk("entry_late", {31'h0, k > 3 * TK + 1}, 32'h0);
    chk("entry_early", {31'h0, k < 3 * TK}, 32'h0);
    $display("test set_and_timer done");
    do_set(32'h0000_0005, 1'b0, 1'b0, 1'b0);
    rd32(6'h00, d);
    chk("cur_en_off", {31'h0, d[10]}, 32'h0);
    rd32(PCT_OFF_ACTIVE, d);
    chk("current_off", d, 32'h0000_0000);
    time_entry(30);
    chk("no_entry", {31'h0, enter_req_o}, 32'h0);
    do_set(32'h0000_0004, 1'b1, 1'b0, 1'b0);
    epc_enable_i <= 1'b0;
    rd32(PCT_OFF_ACTIVE, d);
    chk("current_feat_off", d, 32'h0000_0000);
    rd32(PCT_OFF_SAVED, d);
    chk("saved_kept", d, 32'h0000_0003);
    $display("test disable_paths done");
    // mid-run reset: reported bounds and recovery time must survive
    reset_n_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    reset_n_i <= 1'b1;
    rd32(PCT_OFF_WAKE, d);
    chk("wake_after_reset", d, PCT_DEF_WAKE);
    rd32(PCT_OFF_LOWER, d);
    chk("lower_after_reset", d, 32'h0000_0002);
    rd32(PCT_OFF_UPPER, d);
    chk("upper_after_reset", d, 32'h0000_0014);
    // a zero timer is always in bounds and never starts a count
    epc_enable_i <= 1'b1;
    do_set(PCT_TIMER_OFF, 1'b1, 1'b0, 1'b0);
    rd32(PCT_OFF_ACTIVE, d);
    chk("current_zero", d, PCT_TIMER_OFF);
    time_entry(20);
    chk("zero_no_entry", {31'h0, enter_req_o}, 32'h0);
    $display("test reset_and_zero done");
    complete_run();
  end
endmodule
`default_nettype wire
